// File: logic/cpw_defs.svh
`ifndef CPW_DEFS_SVH
`define CPW_DEFS_SVH

// ****************************************
// mode select encodings
// ****************************************
`define CPW_MODE_OFF 4'h0
`define CPW_MODE_CAP_FALL 4'h4
`define CPW_MODE_CAP_RISE 4'h5
`define CPW_MODE_CAP_4TH 4'h6
`define CPW_MODE_CAP_16TH 4'h7
`define CPW_MODE_CMP_SET 4'h8
`define CPW_MODE_CMP_CLR 4'h9
`define CPW_MODE_CMP_SOFT 4'hA
`define CPW_MODE_CMP_TRIG 4'hB
`define CPW_MODE_CAP_TOP 2'h1
`define CPW_MODE_CMP_TOP 2'h2
`define CPW_MODE_PWM_TOP 2'h3
`define CPW_PWM_LOW_BIT 1

// ****************************************
// field positions and reset values
// ****************************************
`define CPW_CTRL_DUTY_MSB 5
`define CPW_CTRL_DUTY_LSB 4
`define CPW_CTRL_RESET 6'h00
`define CPW_VALUE_RESET 16'h0000
`define CPW_LATCH_RESET 2'h0

// ****************************************
// timing counts
// ****************************************
`define CPW_CAP_4TH_LAST 4'h3
`define CPW_CAP_16TH_LAST 4'hF
`define CPW_CLOCKS_PER_TICK 6'h04
`define CPW_PS_1 2'h0
`define CPW_PS_4 2'h1
`define CPW_PRE_LAST_1 6'h03
`define CPW_PRE_LAST_4 6'h0F
`define CPW_PRE_LAST_16 6'h3F

`endif

// File: logic/cpw_pkg.sv
package cpw_pkg;

	typedef struct packed {
		logic [1:0] duty_low_bits;
		logic [3:0] mode_select_field;
	} cpw_ctrl_t;

	typedef struct packed {
		logic level;
		logic drive;
	} cpw_pin_t;

	typedef struct packed {
		logic [7:0] count;
		logic [1:0] phase;
	} cpw_timebase_t;

endpackage

// File: logic/cpw_timebase.sv
`include "cpw_defs.svh"

module cpw_timebase
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic [1:0] i_prescale,
	input wire logic [7:0] i_period,
	output cpw_pkg::cpw_timebase_t o_base,
	output logic o_wrap
);
	import cpw_pkg::*;

	logic [5:0] pre;
	logic [7:0] count;
	logic [5:0] next_pre;
	logic [7:0] next_count;
	logic inc;

	// ****************************************
	// prescaler helpers
	// ****************************************
	function automatic logic [5:0] pre_last(input logic [1:0] ps);
		unique case (ps)
			`CPW_PS_1: pre_last = `CPW_PRE_LAST_1;
			`CPW_PS_4: pre_last = `CPW_PRE_LAST_4;
			default: pre_last = `CPW_PRE_LAST_16;
		endcase
	endfunction

	// top two prescaler bits extend the count; at 1:1 that is the clock phase
	function automatic logic [1:0] phase_of(input logic [1:0] ps, input logic [5:0] p);
		unique case (ps)
			`CPW_PS_1: phase_of = p[1:0];
			`CPW_PS_4: phase_of = p[3:2];
			default: phase_of = p[5:4];
		endcase
	endfunction

	// ****************************************
	// period counter
	// ****************************************
	always_comb
	begin
		// period is (period+1) * 4 clocks * prescale; no postscaler here
		inc = i_run && (pre == pre_last(i_prescale));
		o_wrap = inc && (count == i_period);
		next_pre = pre;
		next_count = count;
		if (i_run) // sleep holds both counters
		begin
			next_pre = inc ? 6'h00 : pre + 6'h01;
			if (o_wrap)
				next_count = 8'h00;
			else if (inc)
				next_count = count + 8'h01;
		end
		o_base.count = count;
		o_base.phase = phase_of(i_prescale, pre);
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			pre <= 6'h00;
			count <= 8'h00;
		end
		else
		begin
			pre <= next_pre;
			count <= next_count;
		end
	end

	held_in_sleep_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_run |=> $stable(count) && $stable(pre)) else $error("time base moved while stopped");
	wrap_clears_a: assert property (@(posedge i_clock) disable iff (i_rst)
		o_wrap |=> count == 8'h00) else $error("count not cleared at wrap");

endmodule // cpw_timebase

// File: logic/cpw_unit.sv
`include "cpw_defs.svh"

module cpw_unit
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ctrl_wr,
	input cpw_pkg::cpw_ctrl_t i_ctrl_data,
	input wire logic i_value_low_wr,
	input wire logic i_value_high_wr,
	input wire logic [7:0] i_value_data,
	input wire logic i_flag_clear,
	input wire logic [15:0] i_timer_one_count,
	input wire logic i_timer_one_tick,
	input wire logic i_adc_enabled,
	input wire logic i_timer_two_on,
	input wire logic [1:0] i_timer_two_prescale,
	input wire logic [7:0] i_timer_two_period,
	input wire logic i_sleep,
	input wire logic i_pin,
	output cpw_pkg::cpw_ctrl_t o_ctrl,
	output logic [15:0] o_compare_value,
	output logic o_event_flag,
	output logic o_special_trigger,
	output logic o_adc_start,
	output logic o_timer_one_reset,
	output logic [7:0] o_timer_two_count,
	output logic o_pin_out,
	output logic o_pin_oe
);
	import cpw_pkg::*;

	cpw_ctrl_t ctrl;
	logic [15:0] value;
	logic flag;
	logic [3:0] cap_pre;
	logic pin_prev;
	logic cmp_latch;
	logic match_prev;
	logic trigger;
	logic adc_start;
	logic pend;
	logic pwm_level;
	logic [1:0] duty_latch;
	logic [7:0] t2_count;
	cpw_pin_t pin;

	cpw_ctrl_t next_ctrl;
	logic [15:0] next_value;
	logic next_flag;
	logic [3:0] next_cap_pre;
	logic next_cmp_latch;
	logic next_match_prev;
	logic next_trigger;
	logic next_adc_start;
	logic next_pend;
	logic next_pwm_level;
	logic [1:0] next_duty_latch;
	cpw_pin_t next_pin;

	logic [3:0] mode;
	logic is_cap;
	logic is_cmp;
	logic is_pwm;
	logic rise;
	logic fall;
	logic cap_ev;
	logic match;
	logic match_rise;
	logic wrap;
	logic [9:0] duty_new;
	cpw_timebase_t base;

	// ****************************************
	// mode decode
	// ****************************************
	function automatic logic mode_top(input logic [3:0] m, input logic [1:0] top);
		mode_top = (m[3:2] == top);
	endfunction

	function automatic cpw_pin_t pin_of(input logic [3:0] m, input logic latch, input logic level);
		pin_of.level = 1'b0;
		pin_of.drive = 1'b0;
		if (m == `CPW_MODE_CMP_SET || m == `CPW_MODE_CMP_CLR)
		begin
			pin_of.level = latch;
			pin_of.drive = 1'b1;
		end
		else if (mode_top(m, `CPW_MODE_PWM_TOP))
		begin
			pin_of.level = level ^ m[`CPW_PWM_LOW_BIT];
			pin_of.drive = 1'b1;
		end
	endfunction

	cpw_timebase u_timebase
	(
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_run(i_timer_two_on && !i_sleep),
		.i_prescale(i_timer_two_prescale),
		.i_period(i_timer_two_period),
		.o_base(base),
		.o_wrap(wrap)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		mode = ctrl.mode_select_field;
		is_cap = mode_top(mode, `CPW_MODE_CAP_TOP);
		is_cmp = mode_top(mode, `CPW_MODE_CMP_TOP);
		is_pwm = mode_top(mode, `CPW_MODE_PWM_TOP);
		rise = !pin_prev && i_pin;
		fall = pin_prev && !i_pin;
		match = (value == i_timer_one_count);
		match_rise = is_cmp && match && !match_prev;
		duty_new = {value[7:0], ctrl.duty_low_bits};
		unique case (mode)
			`CPW_MODE_CAP_FALL: cap_ev = fall;
			`CPW_MODE_CAP_RISE: cap_ev = rise;
			`CPW_MODE_CAP_4TH: cap_ev = rise && (cap_pre == `CPW_CAP_4TH_LAST);
			`CPW_MODE_CAP_16TH: cap_ev = rise && (cap_pre == `CPW_CAP_16TH_LAST);
			default: cap_ev = 1'b0;
		endcase

		next_ctrl = i_ctrl_wr ? i_ctrl_data : ctrl;
		next_value = value;
		next_flag = flag;
		next_cap_pre = cap_pre;
		next_cmp_latch = cmp_latch;
		next_match_prev = is_cmp && match;
		next_trigger = 1'b0;
		next_adc_start = 1'b0;
		next_pend = pend;
		next_pwm_level = pwm_level;
		next_duty_latch = duty_latch;

		// writes land in the low byte unless a capture event loads the value; high byte is locked in PWM
		if (i_value_low_wr)
			next_value[7:0] = i_value_data;
		if (i_value_high_wr && !is_pwm)
			next_value[15:8] = i_value_data;

		// counter clears on each capture and when leaving capture, not between settings
		if (!is_cap)
			next_cap_pre = 4'h0;
		else if (cap_ev)
			next_cap_pre = 4'h0;
		else if (rise)
			next_cap_pre = cap_pre + 4'h1;

		if (mode == `CPW_MODE_OFF)
		begin
			next_cmp_latch = 1'b0;
			next_pend = 1'b0;
			next_pwm_level = 1'b0;
			next_duty_latch = `CPW_LATCH_RESET;
		end

		if (cap_ev)
			next_value = i_timer_one_count;

		if (match_rise)
		begin
			if (mode == `CPW_MODE_CMP_SET)
				next_cmp_latch = 1'b1;
			else if (mode == `CPW_MODE_CMP_CLR)
				next_cmp_latch = 1'b0;
			else if (mode == `CPW_MODE_CMP_TRIG)
			begin
				next_trigger = 1'b1;
				next_adc_start = i_adc_enabled;
			end
		end

		// timer reset waits for the timer clock edge; a lost match withdraws it
		if (mode != `CPW_MODE_CMP_TRIG || !match)
			next_pend = 1'b0;
		else if (match_rise)
			next_pend = 1'b1;
		else if (i_timer_one_tick)
			next_pend = 1'b0;

		if (is_pwm)
		begin
			if (wrap)
			begin
				next_pwm_level = (duty_new != 10'h000);
				next_value[15:8] = value[7:0];
				next_duty_latch = ctrl.duty_low_bits;
			end
			else if ({base.count, base.phase} == {value[15:8], duty_latch})
				next_pwm_level = 1'b0;
			// a duty beyond the period never matches, so the pin just stays
		end
		else
			next_pwm_level = 1'b0;

		// set wins over a clear in the same cycle
		if (cap_ev || match_rise)
			next_flag = 1'b1;
		else if (i_flag_clear)
			next_flag = 1'b0;

		// pin follows the next mode so a zero write releases it with the control
		next_pin = pin_of(next_ctrl.mode_select_field, next_cmp_latch, next_pwm_level);
	end

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctrl <= `CPW_CTRL_RESET;
			value <= `CPW_VALUE_RESET;
			flag <= 1'b0;
			cap_pre <= 4'h0;
			pin_prev <= 1'b0;
			cmp_latch <= 1'b0;
			match_prev <= 1'b0;
			trigger <= 1'b0;
			adc_start <= 1'b0;
			pend <= 1'b0;
			pwm_level <= 1'b0;
			duty_latch <= `CPW_LATCH_RESET;
			t2_count <= 8'h00;
			pin <= '0;
		end
		else
		begin
			ctrl <= next_ctrl;
			value <= next_value;
			flag <= next_flag;
			cap_pre <= next_cap_pre;
			pin_prev <= i_pin;
			cmp_latch <= next_cmp_latch;
			match_prev <= next_match_prev;
			trigger <= next_trigger;
			adc_start <= next_adc_start;
			pend <= next_pend;
			pwm_level <= next_pwm_level;
			duty_latch <= next_duty_latch;
			t2_count <= base.count;
			pin <= next_pin;
		end
	end

	// the reset line is separate from any overflow path, so no overflow flag
	assign o_ctrl = ctrl;
	assign o_compare_value = value;
	assign o_event_flag = flag;
	assign o_special_trigger = trigger;
	assign o_adc_start = adc_start;
	assign o_timer_one_reset = pend;
	assign o_timer_two_count = t2_count;
	assign o_pin_out = pin.level;
	assign o_pin_oe = pin.drive;

	// ****************************************
	// checks
	// ****************************************
	sequence trig_mode_match;
		mode == `CPW_MODE_CMP_TRIG && match_rise;
	endsequence
	sequence trig_outputs;
		o_special_trigger && o_timer_one_reset && o_adc_start == $past(i_adc_enabled);
	endsequence

	prescaler_cleared_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!is_cap |=> cap_pre == 4'h0) else $error("prescaler not cleared");
	off_releases_a: assert property (@(posedge i_clock) disable iff (i_rst)
		mode == `CPW_MODE_OFF |-> !o_pin_oe && !o_pin_out) else $error("pin held while off");
	capture_copy_a: assert property (@(posedge i_clock) disable iff (i_rst)
		cap_ev |=> o_compare_value == $past(i_timer_one_count) && o_event_flag) else $error("capture lost");
	fourth_edge_a: assert property (@(posedge i_clock) disable iff (i_rst)
		mode == `CPW_MODE_CAP_4TH && cap_ev |=> cap_pre == 4'h0) else $error("prescaler not restarted");
	set_on_match_a: assert property (@(posedge i_clock) disable iff (i_rst)
		mode == `CPW_MODE_CMP_SET && match_rise && !i_ctrl_wr |=> o_pin_out && o_pin_oe)
		else $error("set on match failed");
	soft_mode_a: assert property (@(posedge i_clock) disable iff (i_rst)
		mode == `CPW_MODE_CMP_SOFT |-> !o_pin_oe) else $error("pin driven in soft mode");
	special_trigger_a: assert property (@(posedge i_clock) disable iff (i_rst)
		trig_mode_match |=> trig_outputs) else $error("special trigger missing");
	reset_cancel_a: assert property (@(posedge i_clock) disable iff (i_rst)
		o_timer_one_reset && !match |=> !o_timer_one_reset) else $error("reset not cancelled");
	duty_reload_a: assert property (@(posedge i_clock) disable iff (i_rst)
		is_pwm && wrap |=> o_compare_value[15:8] == $past(value[7:0]) && duty_latch == $past(ctrl.duty_low_bits))
		else $error("duty not reloaded");
	high_locked_a: assert property (@(posedge i_clock) disable iff (i_rst)
		is_pwm && !wrap && !cap_ev |=> $stable(o_compare_value[15:8])) else $error("high byte written in pwm");
	flag_set_wins_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(cap_ev || match_rise) && i_flag_clear |=> o_event_flag) else $error("flag set lost");
	sleep_holds_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_sleep [*2] |=> $stable(o_timer_two_count) && $stable(pwm_level)) else $error("state moved in sleep");

endmodule // cpw_unit

// File: sim/cpw_pin_model.sv
module cpw_pin_model
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_tick_en,
	input wire logic i_timer_reset,
	input wire logic i_level,
	input wire logic i_oe,
	input wire logic i_out,
	output logic [15:0] o_count,
	output logic o_tick,
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// timer one, synchronous to the system clock
	// ****************************************
	// never free-running on its own clock, so compare and capture stay reliable
	assign o_tick = i_tick_en;

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			o_count <= 16'h0000;
		else if (i_tick_en)
			o_count <= i_timer_reset ? 16'h0000 : o_count + 16'h0001;
	end

	// ****************************************
	// pin: unit's driver wins only while enabled
	// ****************************************
	assign o_pin = i_oe ? i_out : i_level;
endmodule // cpw_pin_model

// File: sim/capture_compare_pwm_unit_test.sv
module capture_compare_pwm_unit_test import cpw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_clock, i_rst, i_ctrl_wr, i_value_low_wr, i_value_high_wr, i_flag_clear, i_adc_enabled;
	logic i_timer_two_on, i_sleep, tick_en, src_level, t1_tick, pin;
	logic o_event_flag, o_special_trigger, o_adc_start, o_timer_one_reset, o_pin_out, o_pin_oe;
	logic [7:0] i_value_data, i_timer_two_period, o_timer_two_count;
	logic [1:0] i_timer_two_prescale;
	logic [15:0] o_compare_value, t1_count;
	cpw_ctrl_t i_ctrl_data, o_ctrl;
	int num_errors, n_tests, trig_n, adc_n, seed;

	cpw_pin_model cpw_pin_model_i (.i_clock(i_clock), .i_rst(i_rst), .i_tick_en(tick_en),
		.i_timer_reset(o_timer_one_reset), .i_level(src_level), .i_oe(o_pin_oe), .i_out(o_pin_out),
		.o_count(t1_count), .o_tick(t1_tick), .o_pin(pin));

	cpw_unit cpw_unit_i (.i_clock(i_clock), .i_rst(i_rst), .i_ctrl_wr(i_ctrl_wr), .i_ctrl_data(i_ctrl_data),
		.i_value_low_wr(i_value_low_wr), .i_value_high_wr(i_value_high_wr), .i_value_data(i_value_data),
		.i_flag_clear(i_flag_clear), .i_timer_one_count(t1_count), .i_timer_one_tick(t1_tick),
		.i_adc_enabled(i_adc_enabled), .i_timer_two_on(i_timer_two_on),
		.i_timer_two_prescale(i_timer_two_prescale), .i_timer_two_period(i_timer_two_period),
		.i_sleep(i_sleep), .i_pin(pin), .o_ctrl(o_ctrl), .o_compare_value(o_compare_value),
		.o_event_flag(o_event_flag), .o_special_trigger(o_special_trigger), .o_adc_start(o_adc_start),
		.o_timer_one_reset(o_timer_one_reset), .o_timer_two_count(o_timer_two_count),
		.o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

	// ****************************************
	// clock and event counters
	// ****************************************
	initial
	begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	always @(posedge i_clock)
	begin
		trig_n += o_special_trigger;
		adc_n += o_adc_start;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask

	task automatic wr_ctrl(input logic [3:0] m, input logic [1:0] db);
		i_ctrl_data = {db, m};
		pulse(i_ctrl_wr);
	endtask

	task automatic wr_value(input logic [15:0] v);
		i_value_data = v[7:0];
		pulse(i_value_low_wr);
		i_value_data = v[15:8];
		pulse(i_value_high_wr);
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic cap_hit(input logic [3:0] m, input int k, input logic rise);
		case (m)
			4'h4: return !rise;
			4'h5: return rise;
			4'h6: return rise && (k % 4 == 3);
			default: return rise && (k % 16 == 15);
		endcase
	endfunction

	// active cycles over two periods; zero duty never sets, overlong duty never clears
	// the registered pin drops one clock after the time base match
	function automatic int pwm_hi(input int d, input int p, input int ps, input int per);
		if (d == 0)
			return 0;
		if (d >= 4 * (p + 1))
			return 2 * per;
		return 2 * (d * ps + 1);
	endfunction

	task automatic measure(input int per, input logic act, output int hi);
		logic last;
		last = o_pin_out;
		hi = 0;
		for (int k = 0; k < per; k++)
		begin
			step(1);
			if (o_pin_out === act && last !== act)
				break;
			last = o_pin_out;
		end
		for (int k = 0; k < 2 * per; k++)
		begin
			hi += (o_pin_out === act);
			step(1);
		end
	endtask

	task automatic sleep_hold;
		logic [7:0] tc;
		logic pl;
		i_sleep = 1'b1;
		step(2);
		tc = o_timer_two_count;
		pl = o_pin_out;
		step(40);
		check("sleep_count", o_timer_two_count, tc);
		check("sleep_pin", o_pin_out, pl);
		i_sleep = 1'b0;
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial
	begin
		#480000;
		num_errors++;
		report_and_stop();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		logic [15:0] exp_v;
		logic [3:0] m;
		int p, ps, per, d, hi;
		{i_ctrl_wr, i_value_low_wr, i_value_high_wr, i_flag_clear, i_adc_enabled} = '0;
		{i_timer_two_on, i_sleep, tick_en, src_level} = '0;
		{i_value_data, i_timer_two_period, i_timer_two_prescale} = '0;
		i_ctrl_data = '0;
		seed = $urandom(76496);
		i_rst = 1'b1;
		repeat (8) @(posedge i_clock);
		#1 i_rst = 1'b0;
		step(1);
		check("ctrl_reset", o_ctrl, 16'h0000);
		check("value_reset", o_compare_value, 16'h0000);
		check("oe_reset", o_pin_oe, 16'h0000);
		tick_en = 1'b1;
		for (int mi = 4; mi < 8; mi++)
		begin
			m = mi[3:0];
			wr_ctrl(4'h0, 2'h0);
			wr_ctrl(m, 2'h0);
			step(2);
			pulse(i_flag_clear);
			for (int k = 0; k < 32; k++)
			begin
				src_level = !src_level;
				exp_v = t1_count;
				step(3);
				check("cap_flag", o_event_flag, cap_hit(m, k / 2, src_level));
				if (o_event_flag === 1'b1)
					check("cap_value", o_compare_value, exp_v);
				pulse(i_flag_clear);
			end
		end
		i_adc_enabled = 1'($urandom % 2);
		// set mode twice: the zero write must drop the set latch; 1001 follows directly to see its clear
		for (int mi = 7; mi < 12; mi++)
		begin
			m = (mi == 7) ? 4'h8 : mi[3:0];
			if (m != 4'h9)
				wr_ctrl(4'h0, 2'h0);
			wr_ctrl(m, 2'h0);
			if (m < 4'hA)
				check("latch_start", o_pin_out, m == 4'h9);
			wr_value(t1_count + 16'h0014);
			pulse(i_flag_clear);
			trig_n = 0;
			adc_n = 0;
			step(30);
			check("cmp_flag", o_event_flag, 16'h0001);
			check("cmp_oe", o_pin_oe, m < 4'hA);
			if (m < 4'hA)
				check("cmp_pin", o_pin_out, m == 4'h8);
			if (m == 4'hB)
			begin
				check("trig_count", trig_n, 16'h0001);
				check("adc_count", adc_n, i_adc_enabled);
				check("t1_cleared", t1_count < 16'h0014, 16'h0001);
			end
		end
		tick_en = 1'b0;
		step(1);
		wr_value(t1_count);
		step(2);
		check("reset_pending", o_timer_one_reset, 16'h0001);
		i_value_data = t1_count[7:0] + 8'h01;
		pulse(i_value_low_wr);
		step(2);
		check("reset_cancel", o_timer_one_reset, 16'h0000);
		exp_v = t1_count;
		tick_en = 1'b1;
		step(1);
		check("no_t1_reset", t1_count, exp_v + 16'h0001);
		wr_ctrl(4'h0, 2'h0);
		i_timer_two_on = 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			m = c[0] ? 4'hE : 4'hC;
			i_timer_two_prescale = c[1:0];
			ps = (c == 0) ? 1 : (c == 1) ? 4 : 16;
			// period never shrinks, so the count cannot sit above it and run to 255
			p = c + 1 + $urandom % 2;
			i_timer_two_period = p[7:0];
			per = 4 * (p + 1) * ps;
			for (int j = 0; j < 3; j++)
			begin
				d = (j == 0) ? 1 + $urandom % (4 * p + 3) : (j == 1) ? 4 * p + 5 + $urandom % 8 : 0;
				i_value_data = d[9:2];
				pulse(i_value_low_wr);
				wr_ctrl(m, d[1:0]);
				step(per + 4);
				measure(per, !m[1], hi);
				check("pwm_active", hi, pwm_hi(d, p, ps, per));
				check("duty_copy", o_compare_value[15:8], d[9:2]);
				i_value_data = ~d[9:2];
				pulse(i_value_high_wr);
				check("duty_high_ro", o_compare_value[15:8], d[9:2]);
				if (j == 0)
					sleep_hold();
			end
		end
		wr_ctrl(4'h0, 2'h0);
		check("pwm_release", o_pin_oe, 16'h0000);
		report_and_stop();
	end
endmodule // capture_compare_pwm_unit_test
